/* bench/au_checker.sv */
// Port-level assertions for the looping address unit
`timescale 1ns/1ps
module au_checker (
  input wire logic                       sys_clk,
  input wire logic                       sys_rst,
  input wire addr_unit_pkg::loop_instr_t instr,
  input wire addr_unit_pkg::apb_req_t    apb,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic [31:0]                prdata,
  input wire logic [15:0]                addr_out,
  input wire logic                       addr_out_en,
  input wire logic                       compare_zero_output,
  input wire logic                       alternate_instruction_store,
  input wire logic                       irq
);
  import addr_unit_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  chk_drive_each_instr: assert property (instr.valid |=> addr_out_en)
    else $error("address not driven after instruction");
  chk_idle_holds: assert property (!instr.valid |=> !addr_out_en
    && $stable(addr_out) && $stable(compare_zero_output))
    else $error("outputs moved without instruction");
  chk_alt_cause: assert property (alternate_instruction_store |->
    addr_out_en && compare_zero_output)
    else $error("alternate request without compare flag");
  chk_ready_after_setup: assert property (apb.psel && !apb.penable |=> pready)
    else $error("no ready after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_ready_in_access: assert property (pready |-> apb.psel && apb.penable)
    else $error("ready outside access phase");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
endmodule // au_checker

/* bench/mem_bus_model.sv */
// Data memory side: counts the addresses the unit drives
`timescale 1ns/1ps
module mem_bus_model (
  input  wire logic sys_clk,
  input  wire logic addr_en,
  output int        accesses
);
  initial accesses = 0;
  // Memory only samples while the port is driven
  always @(posedge sys_clk) if (addr_en === 1'b1) accesses <= accesses + 1;
endmodule // mem_bus_model

/* bench/tb.sv */
// Self-checking bench for the looping address unit
`timescale 1ns/1ps
module tb;
  import addr_unit_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  loop_instr_t instr = '0;
  apb_req_t    apb = '0;
  logic        pready, pslverr, irq, aen, cz, alt, er, al, ds = 1'b0;
  logic [31:0] prdata, rd;
  logic [15:0] ao, dd = 16'h0;
  int          errors = 0, num_checks = 0, cyc = 0, n = 0, acc;
  localparam loop_op_t INC = LOOP_INCREMENT;
  localparam loop_op_t DEC = LOOP_DECREMENT;
  always #50 sys_clk = ~sys_clk;
  looping_address_update_unit DUT (.sys_clk, .sys_rst, .instr, .apb,
    .pready, .pslverr, .prdata, .addr_out(ao), .addr_out_en(aen),
    .compare_zero_output(cz), .alternate_instruction_store(alt), .irq);
  mem_bus_model MEM (.sys_clk, .addr_en(aen), .accesses(acc));
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge sys_clk);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    apb.penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    apb <= '0;
  endtask
  task automatic ins(loop_op_t op, logic [3:0] r, logic [1:0] c,
                     logic [15:0] eo, logic ef);
    @(posedge sys_clk);
    instr <= '{1'b1, op, r, 2'h0, c, ds, dd};
    @(posedge sys_clk);
    instr.valid <= 1'b0;
    @(negedge sys_clk);
    n++;
    al = alt;
    cmp("addr", {16'h0, eo}, {16'h0, ao});
    cmp("flag", {31'h0, ef}, {31'h0, cz});
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    bus(1'b0, 12'h000, 32'h0);
    cmp("ctrl reset", 32'h0, rd);
    bus(1'b0, 12'h0fc, 32'h0);
    cmp("unmapped", 32'h1, {31'h0, er});
    bus(1'b1, 12'h080, 32'h4);
    bus(1'b1, 12'h0a0, 32'h5);
    bus(1'b1, 12'h0b0, 32'h2);
    bus(1'b1, 12'h0a4, 32'h0);
    bus(1'b1, 12'h044, 32'h3);
    bus(1'b1, 12'h048, 32'h1);
    bus(1'b1, 12'h000, 32'h1);
    ins(INC, 4'h1, 2'h0, 16'h3, 1'b0);
    ins(INC, 4'h1, 2'h0, 16'h4, 1'b0);
    ins(INC, 4'h1, 2'h0, 16'h5, 1'b1);
    ins(INC, 4'h1, 2'h0, 16'h2, 1'b0);
    ins(DEC, 4'h2, 2'h1, 16'h1, 1'b0);
    ins(DEC, 4'h2, 2'h1, 16'h0, 1'b1);
    ins(DEC, 4'h2, 2'h1, 16'hffff, 1'b0);
    bus(1'b1, 12'h000, 32'h201);
    ins(INC, 4'h1, 2'h0, 16'h4, 1'b0);
    ins(INC, 4'h1, 2'h0, 16'h5, 1'b1);
    ins(INC, 4'h1, 2'h0, 16'h3, 1'b0);
    ds = 1'b1;
    dd = 16'h10;
    ins(LOOP_ADD_OFFSET, 4'h3, 2'h0, 16'h14, 1'b1);
    ds = 1'b0;
    bus(1'b0, 12'h04c, 32'h0);
    cmp("reloaded reg", 32'h2, rd);
    // R2 stands at fffe after the three decrements; minus B0 (4)
    ins(LOOP_SUB_OFFSET, 4'h2, 2'h1, 16'hfffa, 1'b0);
    bus(1'b1, 12'h000, 32'h401);
    bus(1'b1, 12'h044, 32'h5);
    ins(INC, 4'h1, 2'h0, 16'h5, 1'b1);
    cmp("alt pulse", 32'h1, {31'h0, al});
    bus(1'b0, 12'h044, 32'h0);
    cmp("no reload", 32'h6, rd);
    bus(1'b1, 12'h008, 32'h1);
    repeat (2) @(negedge sys_clk);
    cmp("irq raised", 32'h1, {31'h0, irq});
    bus(1'b1, 12'h004, 32'h7);
    repeat (2) @(negedge sys_clk);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    bus(1'b1, 12'h008, 32'h0);
    ins(INC, 4'h1, 2'h0, 16'h6, 1'b1);
    repeat (2) @(negedge sys_clk);
    cmp("irq masked", 32'h0, {31'h0, irq});
    bus(1'b0, 12'h004, 32'h0);
    cmp("status", 32'h5, rd);
    cmp("accesses", n, acc);
    conclude();
  end
endmodule // tb
bind looping_address_update_unit au_checker CHK (.sys_clk, .sys_rst,
  .instr, .apb, .pready, .pslverr, .prdata, .addr_out, .addr_out_en,
  .compare_zero_output, .alternate_instruction_store, .irq);

/* logic/addr_unit_consts.svh */
// Offsets, field positions, reset values and widths of the address unit
`ifndef ADDR_UNIT_CONSTS_SVH
`define ADDR_UNIT_CONSTS_SVH

`define AU_ADDR_W        16
`define AU_CTRL_W        11
`define AU_NUM_R         16
`define AU_NUM_B         6
`define AU_NUM_PAIR      4

// Control word fields
`define AU_CTRL_MASK_LSB 0
`define AU_CTRL_MASK_MSB 3
`define AU_CTRL_BBANK    8
`define AU_CTRL_POST     9
`define AU_CTRL_ALTEN    10
`define AU_CTRL_RESET    11'h000

// Status / interrupt bits
`define AU_EV_W          3
`define AU_EV_CMP        0
`define AU_EV_REINIT     1
`define AU_EV_ALT        2

// APB byte offsets
`define AU_OFS_CTRL      12'h000
`define AU_OFS_STATUS    12'h004
`define AU_OFS_IMASK     12'h008
`define AU_OFS_LAST      12'h00c
`define AU_OFS_R_BASE    12'h040
`define AU_OFS_B_BASE    12'h080
`define AU_OFS_C_BASE    12'h0a0
`define AU_OFS_I_BASE    12'h0b0
`define AU_APB_AW        12

// Offset-select code that takes the offset from the data port
`define AU_BSEL_DATA     2'h3

`endif

/* logic/addr_unit_pkg.sv */
// Types shared by the address unit and its surroundings
package addr_unit_pkg;

  typedef enum logic [1:0] {
    LOOP_ADD_OFFSET,
    LOOP_SUB_OFFSET,
    LOOP_INCREMENT,
    LOOP_DECREMENT
  } loop_op_t;

  typedef struct packed {
    logic        valid;
    loop_op_t    op;
    logic [3:0]  r_sel;
    logic [1:0]  b_sel;
    logic [1:0]  c_sel;
    logic        data_port_select_input;
    logic [15:0] data;
  } loop_instr_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

/* logic/looping_address_update_unit.sv */
// Looping address output, update and reinitialisation unit with APB access
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "addr_unit_consts.svh"

module looping_address_update_unit (
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  input  wire addr_unit_pkg::loop_instr_t instr,
  input  wire addr_unit_pkg::apb_req_t   apb,
  output logic                           pready,
  output logic                           pslverr,
  output logic [31:0]                    prdata,
  output logic [15:0]                    addr_out,
  output logic                           addr_out_en,
  output logic                           compare_zero_output,
  output logic                           alternate_instruction_store,
  output logic                           irq
);
  import addr_unit_pkg::*;

  localparam int AW = `AU_ADDR_W;

  logic [AW-1:0]             r_q [`AU_NUM_R];
  logic [AW-1:0]             b_q [`AU_NUM_B];
  logic [AW-1:0]             c_q [`AU_NUM_PAIR];
  logic [AW-1:0]             i_q [`AU_NUM_PAIR];
  logic [`AU_CTRL_W-1:0]     ctrl_q;
  logic [`AU_EV_W-1:0]       status_q;
  logic [`AU_EV_W-1:0]       imask_q;

  // Datapath terms for the instruction in flight
  logic [AW-1:0]             src;
  logic [AW-1:0]             offset;
  logic [AW-1:0]             updated;
  logic [AW-1:0]             out_addr;
  logic [AW-1:0]             boundary;
  logic                      increasing;
  logic                      flag;
  logic                      reinit;
  logic                      alt_hit;
  logic [2:0]                b_idx;
  logic                      post_mode;

  always_comb begin
    post_mode = ctrl_q[`AU_CTRL_POST];
    // Data port replaces the address register when selected
    src = instr.data_port_select_input ? instr.data
                                       : r_q[instr.r_sel];
    b_idx = ctrl_q[`AU_CTRL_BBANK] ? 3'(instr.b_sel) + 3'd3
                                   : 3'(instr.b_sel);
    if (instr.b_sel == `AU_BSEL_DATA) begin
      offset = instr.data;
    end else begin
      offset = b_q[b_idx];
    end
    case (instr.op)
      LOOP_ADD_OFFSET: begin
        updated    = src + offset;
        increasing = 1'b1;
      end
      LOOP_SUB_OFFSET: begin
        updated    = src - offset;
        increasing = 1'b0;
      end
      LOOP_INCREMENT: begin
        updated    = src + 16'h0001;
        increasing = 1'b1;
      end
      LOOP_DECREMENT: begin
        updated    = src - 16'h0001;
        increasing = 1'b0;
      end
      default: begin
        updated    = src;
        increasing = 1'b1;
      end
    endcase
    // Pre-update outputs the stored value, post-update the new one
    out_addr = post_mode ? updated : src;
    boundary = c_q[instr.c_sel];
    // Comparator sees the output address, so in pre-update a boundary
    // reached now is only seen on the next access of that register;
    // its direction is the current op's, so a raise then lower slips by
    if (increasing) begin
      flag = out_addr >= boundary;
    end else begin
      flag = out_addr <= boundary;
    end
    // Alternate mode overrides the mask entirely
    reinit  = flag && ctrl_q[`AU_CTRL_MASK_LSB + instr.c_sel]
                   && !ctrl_q[`AU_CTRL_ALTEN];
    alt_hit = flag && ctrl_q[`AU_CTRL_ALTEN];
  end

  // APB decode: one-cycle access phase, answer registered in setup
  logic                      setup;
  logic                      wr_en;
  logic [`AU_APB_AW-1:0]     a;
  logic [31:0]               rd_d;
  logic                      err_d;

  assign setup = apb.psel && !apb.penable;
  assign wr_en = apb.psel && apb.penable && pready && apb.pwrite && !pslverr;
  assign a     = apb.paddr;

  always_comb begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    if (a[1:0] != 2'b00) begin
      err_d = 1'b1;
    end else if (a == `AU_OFS_CTRL) begin
      rd_d = 32'(ctrl_q);
    end else if (a == `AU_OFS_STATUS) begin
      rd_d = 32'(status_q);
    end else if (a == `AU_OFS_IMASK) begin
      rd_d = 32'(imask_q);
    end else if (a == `AU_OFS_LAST) begin
      rd_d = {15'h0000, compare_zero_output, addr_out};
    end else if (a >= `AU_OFS_R_BASE && a < `AU_OFS_R_BASE + 12'h040) begin
      rd_d = 32'(r_q[a[5:2]]);
    end else if (a >= `AU_OFS_B_BASE && a < `AU_OFS_B_BASE + 12'h018) begin
      rd_d = 32'(b_q[3'(a[4:2])]);
    end else if (a >= `AU_OFS_C_BASE && a < `AU_OFS_C_BASE + 12'h010) begin
      rd_d = 32'(c_q[a[3:2]]);
    end else if (a >= `AU_OFS_I_BASE && a < `AU_OFS_I_BASE + 12'h010) begin
      rd_d = 32'(i_q[a[3:2]]);
    end else begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && err_d;
      prdata  <= (setup && !apb.pwrite) ? rd_d : 32'h0000_0000;
    end
  end

  // Address registers: instruction write-back has priority over software
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int n = 0; n < `AU_NUM_R; n++) begin
        r_q[n] <= 16'h0000;
      end
    end else begin
      if (wr_en && a >= `AU_OFS_R_BASE && a < `AU_OFS_R_BASE + 12'h040) begin
        r_q[a[5:2]] <= apb.pwdata[AW-1:0];
      end
      if (instr.valid) begin
        // Result lands at the edge closing the instruction cycle
        r_q[instr.r_sel] <= reinit ? i_q[instr.c_sel]
                                   : updated;
      end
    end
  end

  // Offset, boundary and start registers are software written only
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int n = 0; n < `AU_NUM_B; n++) begin
        b_q[n] <= 16'h0000;
      end
      for (int n = 0; n < `AU_NUM_PAIR; n++) begin
        c_q[n] <= 16'h0000;
        i_q[n] <= 16'h0000;
      end
    end else if (wr_en) begin
      if (a >= `AU_OFS_B_BASE && a < `AU_OFS_B_BASE + 12'h018) begin
        b_q[3'(a[4:2])] <= apb.pwdata[AW-1:0];
      end
      if (a >= `AU_OFS_C_BASE && a < `AU_OFS_C_BASE + 12'h010) begin
        c_q[a[3:2]] <= apb.pwdata[AW-1:0];
      end
      if (a >= `AU_OFS_I_BASE && a < `AU_OFS_I_BASE + 12'h010) begin
        i_q[a[3:2]] <= apb.pwdata[AW-1:0];
      end
    end
  end

  // Control word and interrupt mask
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q  <= `AU_CTRL_RESET;
      imask_q <= 3'h0;
    end else if (wr_en) begin
      if (a == `AU_OFS_CTRL) begin
        ctrl_q <= apb.pwdata[`AU_CTRL_W-1:0];
      end
      if (a == `AU_OFS_IMASK) begin
        imask_q <= apb.pwdata[`AU_EV_W-1:0];
      end
    end
  end

  // Sticky events; a new event in the clearing cycle survives
  logic [`AU_EV_W-1:0] ev;
  logic [`AU_EV_W-1:0] clr;

  assign ev  = instr.valid ? {alt_hit, reinit, flag} : 3'h0;
  assign clr = (wr_en && a == `AU_OFS_STATUS) ? apb.pwdata[`AU_EV_W-1:0]
                                              : 3'h0;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= 3'h0;
      irq      <= 1'b0;
    end else begin
      status_q <= (status_q & ~clr) | ev;
      irq      <= |(((status_q & ~clr) | ev) & imask_q);
    end
  end

  // Address port and compare pin, registered for clean outputs
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_out                    <= 16'h0000;
      addr_out_en                 <= 1'b0;
      compare_zero_output         <= 1'b0;
      alternate_instruction_store <= 1'b0;
    end else begin
      addr_out_en <= instr.valid;
      if (instr.valid) begin
        addr_out            <= out_addr;
        compare_zero_output <= flag;
      end
      // Requests the alternate instruction for the following cycle
      alternate_instruction_store <= instr.valid && alt_hit;
    end
  end

endmodule // looping_address_update_unit
